// ==== verilog/fsc_pkg.sv ====
// Purpose: shared constants for the fault status capture block
// Assumes: five-bit fault code is {bit 10, bits 3:0} of each status word
// Notes:   source vectors are ordered from highest (bit 0) to lowest priority
package fsc_pkg;

  // ------------------------------------------------------------
  // fault codes
  // ------------------------------------------------------------
  localparam logic [4:0] FSC_CODE_ALIGN = 5'h01;
  localparam logic [4:0] FSC_CODE_BACKGROUND = 5'h00;
  localparam logic [4:0] FSC_CODE_PERM = 5'h0D;
  localparam logic [4:0] FSC_CODE_SYNC_EXT = 5'h08;
  localparam logic [4:0] FSC_CODE_ASYNC_EXT = 5'h16;
  localparam logic [4:0] FSC_CODE_SYNC_ECC = 5'h19;
  localparam logic [4:0] FSC_CODE_ASYNC_ECC = 5'h18;
  localparam logic [4:0] FSC_CODE_DEBUG = 5'h02;

  // ------------------------------------------------------------
  // source vector positions, highest priority first
  // ------------------------------------------------------------
  localparam int FSC_SRC_ALIGN = 0;
  localparam int FSC_SRC_BACKGROUND = 1;
  localparam int FSC_SRC_PERM = 2;
  localparam int FSC_SRC_SYNC_EXT = 3;
  localparam int FSC_SRC_ASYNC_EXT = 4;
  localparam int FSC_SRC_SYNC_ECC = 5;
  localparam int FSC_SRC_ASYNC_ECC = 6;
  localparam int FSC_SRC_DEBUG = 7;
  localparam int FSC_SRC_COUNT = 8;

  // ------------------------------------------------------------
  // status word field positions
  // ------------------------------------------------------------
  localparam int FSC_BIT_KIND = 12;
  localparam int FSC_BIT_DIR = 11;
  localparam int FSC_BIT_CODE_HI = 10;
  localparam int FSC_CODE_LO_MSB = 3;

  // ------------------------------------------------------------
  // coprocessor coordinates and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] FSC_CP_CRN = 4'h5;
  localparam logic [2:0] FSC_CP_OP1 = 3'h0;
  localparam logic [3:0] FSC_CP_CRM = 4'h0;
  localparam logic [2:0] FSC_CP_OP2_DATA = 3'h0;
  localparam logic [2:0] FSC_CP_OP2_INST = 3'h1;
  localparam logic [4:0] FSC_RST_CODE = 5'h00;
  localparam logic FSC_RST_BIT = 1'b0;

endpackage

// ==== verilog/fsc_prio_enc.sv ====
// Purpose: picks the winning fault source and gives its code
// Assumes: src bit 0 is the highest priority source
// Notes:   purely combinational; any is low when no source is raised
`timescale 1ns/1ps
module fsc_prio_enc
  import fsc_pkg::*;
(
  // raised fault sources
  input wire logic [FSC_SRC_COUNT-1:0] src,
  // chosen fault
  output logic [4:0] code,
  output logic any,
  output logic isExt,
  output logic addrValid,
  output logic addrUnpred
);

  // ------------------------------------------------------------
  // priority selection
  // ------------------------------------------------------------
  wire selAlign = src[FSC_SRC_ALIGN];
  wire selBack = src[FSC_SRC_BACKGROUND];
  wire selPerm = src[FSC_SRC_PERM];
  wire selSExt = src[FSC_SRC_SYNC_EXT];
  wire selAExt = src[FSC_SRC_ASYNC_EXT];
  wire selSEcc = src[FSC_SRC_SYNC_ECC];
  wire selAEcc = src[FSC_SRC_ASYNC_ECC];

  // first raised source wins; only the eight defined codes can leave here
  assign code = selAlign ? FSC_CODE_ALIGN :
                selBack ? FSC_CODE_BACKGROUND :
                selPerm ? FSC_CODE_PERM :
                selSExt ? FSC_CODE_SYNC_EXT :
                selAExt ? FSC_CODE_ASYNC_EXT :
                selSEcc ? FSC_CODE_SYNC_ECC :
                selAEcc ? FSC_CODE_ASYNC_ECC :
                FSC_CODE_DEBUG;

  // address qualifiers follow the winning code
  assign any = |src;
  assign isExt = (code == FSC_CODE_SYNC_EXT) || (code == FSC_CODE_ASYNC_EXT);
  assign addrUnpred = (code == FSC_CODE_ASYNC_EXT) || (code == FSC_CODE_ASYNC_ECC);
  assign addrValid = any && !addrUnpred && (code != FSC_CODE_DEBUG);

endmodule

// ==== verilog/fsc_cp_decode.sv ====
// Purpose: decodes a system-control coprocessor access to the two records
// Assumes: access fields are stable while cpValid is high
// Notes:   a user-mode hit is refused, never performed
`timescale 1ns/1ps
module fsc_cp_decode
  import fsc_pkg::*;
(
  // access request
  input wire logic valid,
  input wire logic priv,
  input wire logic [3:0] crn,
  input wire logic [2:0] op1,
  input wire logic [3:0] crm,
  input wire logic [2:0] op2,
  // decode result
  output logic selData,
  output logic selInst,
  output logic hit,
  output logic undef
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire baseMatch = valid && (crn == FSC_CP_CRN) && (op1 == FSC_CP_OP1) && (crm == FSC_CP_CRM);
  wire dataMatch = baseMatch && (op2 == FSC_CP_OP2_DATA);
  wire instMatch = baseMatch && (op2 == FSC_CP_OP2_INST);

  // privilege gate: user mode hits become undefined-instruction requests
  assign selData = dataMatch && priv;
  assign selInst = instMatch && priv;
  assign hit = dataMatch || instMatch;
  assign undef = hit && !priv;

endmodule

// ==== verilog/fsc_capture.sv ====
// Purpose: holds the data and instruction fault status records
// Assumes: abort commit strobes are one cycle and come from exception entry
// Notes:   a capture and a software write in one cycle resolve to the capture
`timescale 1ns/1ps

module fsc_capture
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // data abort entry
  input wire logic dAbortCommit,
  input wire logic [FSC_SRC_COUNT-1:0] dFaultSrc,
  input wire logic dExtSlave,
  input wire logic dExclUnsup,
  input wire logic dWrite,
  // instruction abort entry
  input wire logic iAbortCommit,
  input wire logic [FSC_SRC_COUNT-1:0] iFaultSrc,
  input wire logic iExtSlave,
  // coprocessor access
  input wire logic cpValid,
  input wire logic cpWrite,
  input wire logic cpPriv,
  input wire logic [3:0] cpCrn,
  input wire logic [2:0] cpOp1,
  input wire logic [3:0] cpCrm,
  input wire logic [2:0] cpOp2,
  input wire logic [31:0] cpWdata,
  output logic cpHit,
  output logic cpUndef,
  output logic [31:0] cpRdata,
  output logic cpRvalid,
  // fault address holder link
  output logic dFarLoad,
  output logic dFarUnpred,
  output logic iFarLoad,
  output logic iFarUnpred,
  // record views
  output logic [31:0] dataFaultStatus,
  output logic [31:0] instFaultStatus
);

  // ------------------------------------------------------------
  // source encoders and access decode
  // ------------------------------------------------------------
  logic [4:0] dEncCode;
  logic dEncAny;
  logic dEncExt;
  logic dEncValid;
  logic dEncUnpred;
  logic [4:0] iEncCode;
  logic iEncAny;
  logic iEncExt;
  logic iEncValid;
  logic iEncUnpred;
  logic selData;
  logic selInst;

  fsc_prio_enc u_dEnc (
    .src(dFaultSrc),
    .code(dEncCode),
    .any(dEncAny),
    .isExt(dEncExt),
    .addrValid(dEncValid),
    .addrUnpred(dEncUnpred)
  );

  fsc_prio_enc u_iEnc (
    .src(iFaultSrc),
    .code(iEncCode),
    .any(iEncAny),
    .isExt(iEncExt),
    .addrValid(iEncValid),
    .addrUnpred(iEncUnpred)
  );

  fsc_cp_decode u_dec (
    .valid(cpValid),
    .priv(cpPriv),
    .crn(cpCrn),
    .op1(cpOp1),
    .crm(cpCrm),
    .op2(cpOp2),
    .selData(selData),
    .selInst(selInst),
    .hit(cpHit),
    .undef(cpUndef)
  );

  // ------------------------------------------------------------
  // capture and write qualification
  // ------------------------------------------------------------
  // a commit with no raised source carries no cause, so it is dropped
  wire dCapture = dAbortCommit && dEncAny;
  wire iCapture = iAbortCommit && iEncAny;
  wire dSwWrite = selData && cpWrite;
  wire iSwWrite = selInst && cpWrite;
  wire dKindHw = dEncExt && (dExtSlave || dExclUnsup);
  wire iKindHw = iEncExt && iExtSlave;
  wire [4:0] wrCode = {cpWdata[FSC_BIT_CODE_HI], cpWdata[FSC_CODE_LO_MSB:0]};

  // ------------------------------------------------------------
  // record next values
  // ------------------------------------------------------------
  logic [4:0] dCode_q;
  logic [4:0] dCode_d;
  logic dKind_q;
  logic dKind_d;
  logic dDir_q;
  logic dDir_d;
  logic [4:0] iCode_q;
  logic [4:0] iCode_d;
  logic iKind_q;
  logic iKind_d;

  // hardware capture outranks a software write in the same cycle
  assign dCode_d = dCapture ? dEncCode : dSwWrite ? wrCode : dCode_q;
  assign dKind_d = dCapture ? dKindHw : dSwWrite ? cpWdata[FSC_BIT_KIND] : dKind_q;
  assign dDir_d = dCapture ? dWrite : dSwWrite ? cpWdata[FSC_BIT_DIR] : dDir_q;
  assign iCode_d = iCapture ? iEncCode : iSwWrite ? wrCode : iCode_q;
  assign iKind_d = iCapture ? iKindHw : iSwWrite ? cpWdata[FSC_BIT_KIND] : iKind_q;

  // record flops, updated on the commit edge itself
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dCode_q <= FSC_RST_CODE;
      dKind_q <= FSC_RST_BIT;
      dDir_q <= FSC_RST_BIT;
      iCode_q <= FSC_RST_CODE;
      iKind_q <= FSC_RST_BIT;
    end else begin
      dCode_q <= dCode_d;
      dKind_q <= dKind_d;
      dDir_q <= dDir_d;
      iCode_q <= iCode_d;
      iKind_q <= iKind_d;
    end
  end

  // ------------------------------------------------------------
  // status word assembly
  // ------------------------------------------------------------
  // unused fields are wired to zero, so writes to them cannot stick
  assign dataFaultStatus = {19'h0_0000, dKind_q, dDir_q, dCode_q[4], 2'h0, 4'h0,
                            dCode_q[3:0]};
  assign instFaultStatus = {19'h0_0000, iKind_q, 1'b0, iCode_q[4], 2'h0, 4'h0,
                            iCode_q[3:0]};

  // fault address holder strobes, same cycle as the commit
  assign dFarLoad = dCapture && dEncValid;
  assign dFarUnpred = dCapture && dEncUnpred;
  assign iFarLoad = iCapture && iEncValid;
  assign iFarUnpred = iCapture && iEncUnpred;

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [31:0] cpRdata_q;
  logic [31:0] cpRdata_d;
  logic cpRvalid_q;
  wire rdTake = (selData || selInst) && !cpWrite;

  // read data is the pre-update value of the selected record
  assign cpRdata_d = !rdTake ? cpRdata_q : selData ? dataFaultStatus : instFaultStatus;

  // registered answer, one cycle after the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpRdata_q <= 32'h0000_0000;
      cpRvalid_q <= 1'b0;
    end else begin
      cpRdata_q <= cpRdata_d;
      cpRvalid_q <= rdTake;
    end
  end

  assign cpRdata = cpRdata_q;
  assign cpRvalid = cpRvalid_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  wire dIsLegal = (dCode_q == FSC_CODE_ALIGN) || (dCode_q == FSC_CODE_BACKGROUND) ||
                  (dCode_q == FSC_CODE_PERM) || (dCode_q == FSC_CODE_SYNC_EXT) ||
                  (dCode_q == FSC_CODE_ASYNC_EXT) || (dCode_q == FSC_CODE_SYNC_ECC) ||
                  (dCode_q == FSC_CODE_ASYNC_ECC) || (dCode_q == FSC_CODE_DEBUG);

  // a hardware capture always lands on a defined code; software may load others
  property p_legal_code;
    @(posedge core_clk) disable iff (rst)
      dCapture |=> dIsLegal;
  endproperty
  a_legal_code: assert property (p_legal_code) else $error("reserved data code");

  property p_align_wins;
    @(posedge core_clk) disable iff (rst)
      (dAbortCommit && dFaultSrc[FSC_SRC_ALIGN]) |-> dFarLoad ##1 (dCode_q == 5'h01);
  endproperty
  a_align_wins: assert property (p_align_wins) else $error("alignment lost");

  property p_sync_ecc;
    @(posedge core_clk) disable iff (rst)
      (dAbortCommit && dFaultSrc == 8'h20) |-> dFarLoad ##1
        ((dCode_q == 5'h19) && !dataFaultStatus[12]);
  endproperty
  a_sync_ecc: assert property (p_sync_ecc) else $error("sync ecc wrong");

  property p_async_ext;
    @(posedge core_clk) disable iff (rst)
      (dAbortCommit && dFaultSrc == 8'h10) |-> (!dFarLoad && dFarUnpred) ##1
        (dCode_q == 5'h16);
  endproperty
  a_async_ext: assert property (p_async_ext) else $error("async ext wrong");

  property p_nonext_kind;
    @(posedge core_clk) disable iff (rst)
      (dCapture && !dEncExt) |=> !dataFaultStatus[12];
  endproperty
  a_nonext_kind: assert property (p_nonext_kind) else $error("kind bit set");

  property p_direction;
    @(posedge core_clk) disable iff (rst)
      dCapture |=> (dataFaultStatus[11] == $past(dWrite));
  endproperty
  a_direction: assert property (p_direction) else $error("direction lost");

  property p_user_blocked;
    @(posedge core_clk) disable iff (rst)
      (cpValid && !cpPriv && !dAbortCommit && !iAbortCommit) |=>
        $stable(dataFaultStatus) && $stable(instFaultStatus) && !cpRvalid;
  endproperty
  a_user_blocked: assert property (p_user_blocked) else $error("user access took");

  property p_zero_fields;
    @(posedge core_clk) disable iff (rst)
      cpRvalid |-> (cpRdata[31:13] == 19'h0_0000) && (cpRdata[9:4] == 6'h00);
  endproperty
  a_zero_fields: assert property (p_zero_fields) else $error("reserved bits set");

  property p_inst_dir;
    @(posedge core_clk) disable iff (rst)
      (iSwWrite && !iCapture) |=>
        !instFaultStatus[11] && (instFaultStatus[10] == $past(cpWdata[10]));
  endproperty
  a_inst_dir: assert property (p_inst_dir) else $error("inst bit11 set");

  property p_inst_capture;
    @(posedge core_clk) disable iff (rst)
      iCapture |=> (iCode_q == $past(iEncCode)) && (iKind_q == $past(iKindHw));
  endproperty
  a_inst_capture: assert property (p_inst_capture) else $error("inst not replaced");

  property p_perm_code;
    @(posedge core_clk) disable iff (rst)
      (dAbortCommit && (dFaultSrc[2:0] == 3'h4)) |-> dFarLoad ##1 (dCode_q == 5'h0D);
  endproperty
  a_perm_code: assert property (p_perm_code) else $error("permission code wrong");

  // decode or bus errors on an external abort leave the kind bit low
  property p_data_kind_lo;
    @(posedge core_clk) disable iff (rst)
      (dAbortCommit && ((dFaultSrc[3:0] == 4'h8) || (dFaultSrc[4:0] == 5'h10)) &&
        !dExtSlave && !dExclUnsup) |=> !dataFaultStatus[12];
  endproperty
  a_data_kind_lo: assert property (p_data_kind_lo) else $error("kind bit set");

  property p_data_kind_hi;
    @(posedge core_clk) disable iff (rst)
      (dAbortCommit && ((dFaultSrc[3:0] == 4'h8) || (dFaultSrc[4:0] == 5'h10)) &&
        (dExtSlave || dExclUnsup)) |=> dataFaultStatus[12];
  endproperty
  a_data_kind_hi: assert property (p_data_kind_hi) else $error("kind bit clear");

  property p_inst_kind;
    @(posedge core_clk) disable iff (rst)
      (iAbortCommit && (iFaultSrc[3:0] == 4'h8)) |=> (instFaultStatus[12] == $past(iExtSlave));
  endproperty
  a_inst_kind: assert property (p_inst_kind) else $error("inst kind wrong");

  // a lone software write lands on the writable fields only
  property p_data_write;
    @(posedge core_clk) disable iff (rst)
      (dSwWrite && !dCapture) |=> (dataFaultStatus[9:4] == 6'h00) &&
        (dataFaultStatus[12:10] == $past(cpWdata[12:10])) &&
        (dataFaultStatus[3:0] == $past(cpWdata[3:0]));
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write wrong");

  c_data_abort: cover property (@(posedge core_clk) disable iff (rst) dCapture && dEncExt);
  c_inst_abort: cover property (@(posedge core_clk) disable iff (rst) iCapture);
  c_inst_ext: cover property (@(posedge core_clk) disable iff (rst) iCapture && iEncExt);
  c_sw_write: cover property (@(posedge core_clk) disable iff (rst) dSwWrite ##1 cpValid);
  c_user_undef: cover property (@(posedge core_clk) disable iff (rst) cpUndef);

endmodule

// ==== verification/fsc_capture_tb.sv ====
// Purpose: self-checking bench for the fault status capture block
// Assumes: inputs change on the falling edge, outputs settle 1 ns after an edge
// Notes:   table rows hold the abort captures; coprocessor cases follow by hand
`timescale 1ns/1ps
module fsc_capture_tb
  import fsc_pkg::*;
;
  // ------------------------------------------------------------
  // signals and instance
  // ------------------------------------------------------------
  typedef struct packed {
    logic side;
    logic [7:0] src;
    logic slv;
    logic exc;
    logic wr;
    logic [31:0] word;
    logic unp;
    logic ld;
  } fsc_row_type;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic dAbortCommit = 1'b0, dExtSlave = 1'b0, dExclUnsup = 1'b0, dWrite = 1'b0;
  logic iAbortCommit = 1'b0, iExtSlave = 1'b0;
  logic [7:0] dFaultSrc = 8'h00, iFaultSrc = 8'h00;
  logic cpValid = 1'b0, cpWrite = 1'b0, cpPriv = 1'b0;
  logic [3:0] cpCrn = 4'h0, cpCrm = 4'h0;
  logic [2:0] cpOp1 = 3'h0, cpOp2 = 3'h0;
  logic [31:0] cpWdata = 32'h0000_0000;
  logic cpHit, cpUndef, cpRvalid, dFarLoad, dFarUnpred, iFarLoad, iFarUnpred;
  logic [31:0] cpRdata, dataFaultStatus, instFaultStatus;
  logic [31:0] expD, expI;
  int fails = 0;
  int checks = 0;
  fsc_row_type rows [18];

  fsc_capture u_dut (.core_clk(core_clk), .rst(rst), .dAbortCommit(dAbortCommit),
    .dFaultSrc(dFaultSrc), .dExtSlave(dExtSlave), .dExclUnsup(dExclUnsup),
    .dWrite(dWrite), .iAbortCommit(iAbortCommit), .iFaultSrc(iFaultSrc),
    .iExtSlave(iExtSlave), .cpValid(cpValid), .cpWrite(cpWrite), .cpPriv(cpPriv),
    .cpCrn(cpCrn), .cpOp1(cpOp1), .cpCrm(cpCrm), .cpOp2(cpOp2), .cpWdata(cpWdata),
    .cpHit(cpHit), .cpUndef(cpUndef), .cpRdata(cpRdata), .cpRvalid(cpRvalid),
    .dFarLoad(dFarLoad), .dFarUnpred(dFarUnpred), .iFarLoad(iFarLoad),
    .iFarUnpred(iFarUnpred), .dataFaultStatus(dataFaultStatus),
    .instFaultStatus(instFaultStatus));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // compare and access tasks
  // ------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one coprocessor access, then an idle cycle so valid never toggles twice at once
  task automatic cpDo(input logic wr, input logic pv, input logic [3:0] crn,
      input logic [2:0] op2, input logic [31:0] wd, input logic eHit,
      input logic eUnd, input logic eRv, input logic [31:0] eRd);
    @(negedge core_clk);
    cpValid = 1'b1;
    cpWrite = wr;
    cpPriv = pv;
    cpCrn = crn;
    cpOp2 = op2;
    cpWdata = wd;
    #1;
    chk1("cpHit", eHit, cpHit);
    chk1("cpUndef", eUnd, cpUndef);
    @(negedge core_clk);
    cpValid = 1'b0;
    chk1("cpRvalid", eRv, cpRvalid);
    if (eRv) begin
      chk32("cpRdata", eRd, cpRdata);
    end
  endtask

  task automatic views();
    chk32("dataFaultStatus", expD, dataFaultStatus);
    chk32("instFaultStatus", expI, instFaultStatus);
  endtask

  task automatic results();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole run needs about 50 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    results();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rows = '{
      '{1'b0, 8'h01, 1'b0, 1'b0, 1'b1, 32'h0000_0801, 1'b0, 1'b1},
      '{1'b0, 8'h02, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 1'b0, 1'b1},
      '{1'b0, 8'h04, 1'b1, 1'b1, 1'b0, 32'h0000_000D, 1'b0, 1'b1},
      '{1'b0, 8'h08, 1'b0, 1'b0, 1'b1, 32'h0000_0808, 1'b0, 1'b1},
      '{1'b0, 8'h08, 1'b1, 1'b0, 1'b0, 32'h0000_1008, 1'b0, 1'b1},
      '{1'b0, 8'h08, 1'b0, 1'b1, 1'b0, 32'h0000_1008, 1'b0, 1'b1},
      '{1'b0, 8'h10, 1'b1, 1'b0, 1'b0, 32'h0000_1406, 1'b1, 1'b0},
      '{1'b0, 8'h20, 1'b0, 1'b0, 1'b0, 32'h0000_0409, 1'b0, 1'b1},
      '{1'b0, 8'h40, 1'b0, 1'b0, 1'b1, 32'h0000_0C08, 1'b1, 1'b0},
      '{1'b0, 8'h80, 1'b0, 1'b0, 1'b0, 32'h0000_0002, 1'b0, 1'b0},
      '{1'b0, 8'hFE, 1'b1, 1'b0, 1'b0, 32'h0000_0000, 1'b0, 1'b1},
      '{1'b0, 8'hF0, 1'b0, 1'b0, 1'b0, 32'h0000_0406, 1'b1, 1'b0},
      '{1'b0, 8'hE0, 1'b0, 1'b0, 1'b0, 32'h0000_0409, 1'b0, 1'b1},
      '{1'b1, 8'h09, 1'b1, 1'b0, 1'b1, 32'h0000_0001, 1'b0, 1'b1},
      '{1'b1, 8'h08, 1'b1, 1'b0, 1'b0, 32'h0000_1008, 1'b0, 1'b1},
      '{1'b1, 8'h10, 1'b0, 1'b0, 1'b0, 32'h0000_0406, 1'b1, 1'b0},
      '{1'b1, 8'h80, 1'b0, 1'b0, 1'b0, 32'h0000_0002, 1'b0, 1'b0},
      '{1'b1, 8'h20, 1'b1, 1'b0, 1'b0, 32'h0000_0409, 1'b0, 1'b1}};
    expD = 32'h0000_0000;
    expI = 32'h0000_0000;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    views();
    chk1("cpRvalid", 1'b0, cpRvalid);
    // back-to-back captures, one per cycle, covering every source code
    foreach (rows[i]) begin
      @(negedge core_clk);
      dAbortCommit = ~rows[i].side;
      iAbortCommit = rows[i].side;
      dFaultSrc = rows[i].src;
      iFaultSrc = rows[i].src;
      dExtSlave = rows[i].slv;
      iExtSlave = rows[i].slv;
      dExclUnsup = rows[i].exc;
      dWrite = rows[i].wr;
      #1;
      if (!rows[i].unp) begin
        chk1("farLoad", rows[i].ld, rows[i].side ? iFarLoad : dFarLoad);
      end
      chk1("farUnpred", rows[i].unp, rows[i].side ? iFarUnpred : dFarUnpred);
      chk1("otherLoad", 1'b0, rows[i].side ? dFarLoad : iFarLoad);
      if (rows[i].side) begin
        expI = rows[i].word;
      end else begin
        expD = rows[i].word;
      end
      @(posedge core_clk);
      #1;
      views();
    end
    @(negedge core_clk);
    dAbortCommit = 1'b0;
    iAbortCommit = 1'b0;
    // coprocessor reads and writes
    cpDo(1'b0, 1'b1, 4'h5, 3'h0, 32'h0, 1'b1, 1'b0, 1'b1, expD);
    cpDo(1'b0, 1'b1, 4'h5, 3'h1, 32'h0, 1'b1, 1'b0, 1'b1, expI);
    cpDo(1'b1, 1'b1, 4'h5, 3'h0, 32'hFFFF_FFFF, 1'b1, 1'b0, 1'b0, 32'h0);
    cpDo(1'b1, 1'b1, 4'h5, 3'h1, 32'hFFFF_FFFF, 1'b1, 1'b0, 1'b0, 32'h0);
    expD = 32'h0000_1C0F;
    expI = 32'h0000_140F;
    views();
    cpDo(1'b0, 1'b1, 4'h5, 3'h0, 32'h0, 1'b1, 1'b0, 1'b1, expD);
    // user mode is refused, misses are ignored
    cpDo(1'b1, 1'b0, 4'h5, 3'h0, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0);
    cpDo(1'b0, 1'b0, 4'h5, 3'h1, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0);
    cpDo(1'b1, 1'b1, 4'h6, 3'h0, 32'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    cpDo(1'b1, 1'b1, 4'h5, 3'h2, 32'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    // the other two coordinates must match as well
    cpCrm = 4'h1;
    cpDo(1'b1, 1'b1, 4'h5, 3'h0, 32'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    cpCrm = 4'h0;
    cpOp1 = 3'h1;
    cpDo(1'b1, 1'b1, 4'h5, 3'h1, 32'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    cpOp1 = 3'h0;
    views();
    // capture and write in one cycle: the capture wins
    @(negedge core_clk);
    dAbortCommit = 1'b1;
    dFaultSrc = 8'h01;
    dWrite = 1'b0;
    cpValid = 1'b1;
    cpWrite = 1'b1;
    cpPriv = 1'b1;
    cpCrn = 4'h5;
    cpOp2 = 3'h0;
    cpWdata = 32'h0000_0000;
    @(posedge core_clk);
    #1;
    chk32("captureWins", 32'h0000_0001, dataFaultStatus);
    // a commit with no source raised leaves the record alone
    @(negedge core_clk);
    cpValid = 1'b0;
    dFaultSrc = 8'h00;
    @(posedge core_clk);
    #1;
    chk32("emptyCommit", 32'h0000_0001, dataFaultStatus);
    // second reset in mid-run clears both records
    @(negedge core_clk);
    dAbortCommit = 1'b0;
    rst = 1'b1;
    #1;
    expD = 32'h0000_0000;
    expI = 32'h0000_0000;
    views();
    @(negedge core_clk);
    rst = 1'b0;
    views();
    // the first edge after release already takes a capture
    dAbortCommit = 1'b1;
    dFaultSrc = 8'h04;
    dWrite = 1'b1;
    @(posedge core_clk);
    #1;
    chk32("afterReset", 32'h0000_080D, dataFaultStatus);
    @(negedge core_clk);
    dAbortCommit = 1'b0;
    repeat (2) @(negedge core_clk);
    results();
  end
endmodule
